// file: tb/msd_ext_mem.sv
`timescale 1ns/1ps
module msd_ext_mem (
    // Clock and strobe.
    input wire logic sys_clk_in,
    input wire logic ext_rd_n_in,
    // Address and returned data.
    input wire logic [13:0] ext_addr_in,
    output logic [23:0] ext_data_out
);
    logic [23:0] last_q = 24'h000000;

    // Remember the last word so a released bus can show its inverse, never a stale match.
    always @(posedge sys_clk_in) begin
        if (!ext_rd_n_in) begin
            last_q <= {10'h015, ext_addr_in};
        end
    end

    // Answer at once while read is low; the word encodes the address it came from.
    assign ext_data_out = ext_rd_n_in ? ~last_q : {10'h015, ext_addr_in};
endmodule

// file: tb/tb_msd_decoder.sv
`timescale 1ns/1ps
module tb_msd_decoder;
    import msd_pkg::*;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic map_pin = 1'b0;
    logic req = 1'b0;
    logic wr = 1'b0;
    logic err;
    logic pready;
    logic pslverr;
    logic done;
    logic rd_n;
    logic sel_pm_n, sel_dm_n, sel_bm_n, sel_io_n, sel_comp_n;
    logic creg;
    logic grant = 1'b0;
    logic [1:0] sp = 2'h0;
    logic [3:0] seen;
    logic [7:0] paddr = 8'h00;
    logic [7:0] pg = 8'h00;
    logic [13:0] ca = 14'h0000;
    logic [13:0] ext_addr;
    logic [13:0] cap_a;
    logic [23:0] wd = 24'h000000;
    logic [23:0] ed_in, ed_out, rdata, cap_d, fd;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    int bad_count = 0;
    int tests_run = 0;
    int sel_cnt = 0;
    int comp_cnt = 0;
    int cyc = 0;

    always #25 sys_clk_in = ~sys_clk_in;

    msd_decoder msd_decoder_inst (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .map_select_pin_in(map_pin), .core_req_in(req),
        .core_space_in(sp), .core_write_in(wr), .core_addr_in(ca), .core_page_in(pg), .core_wdata_in(wd),
        .fetch_addr_in(ca), .fetch_data_out(fd), .core_rdata_out(rdata), .core_done_out(done),
        .core_busy_out(), .core_ext_out(), .core_creg_out(creg), .bus_grant_in(grant), .ext_data_in(ed_in),
        .ext_data_out(ed_out), .ext_data_hi_oe_n_out(), .ext_data_lo_oe_n_out(), .ext_addr_out(ext_addr),
        .ext_addr_oe_n_out(), .ext_rd_n_out(rd_n), .ext_wr_n_out(), .program_memory_select_n_out(sel_pm_n),
        .data_memory_select_n_out(sel_dm_n), .byte_memory_select_n_out(sel_bm_n),
        .io_space_select_n_out(sel_io_n), .composite_select_n_out(sel_comp_n));

    msd_ext_mem msd_ext_mem_inst (.sys_clk_in(sys_clk_in), .ext_rd_n_in(rd_n), .ext_addr_in(ext_addr),
        .ext_data_out(ed_in));

    // ************************************************************
    // Select monitor and hang guard.
    // ************************************************************
    // Sampled mid-cycle so every registered select has settled.
    always @(negedge sys_clk_in) begin
        if ({sel_io_n, sel_bm_n, sel_dm_n, sel_pm_n} != MSD_SEL_NONE_N) begin
            sel_cnt++;
            seen |= ~{sel_io_n, sel_bm_n, sel_dm_n, sel_pm_n};
            cap_a = ext_addr;
            cap_d = ed_out;
        end
        if (sel_comp_n === 1'b0) comp_cnt++;
        cyc++;
        if (cyc > 5000) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // ************************************************************
    // APB master and core request tasks.
    // ************************************************************
    // The request stays untouched until the edge where pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        pen <= 1'b1;
        do @(posedge sys_clk_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic acc(input logic [1:0] s, input logic w, input logic [13:0] a, input logic [7:0] p,
                       input int n, input logic [3:0] sel, input int nc, input logic [13:0] xa);
        int i;
        i = 0;
        @(posedge sys_clk_in);
        req <= 1'b1;
        sp <= s;
        wr <= w;
        ca <= a;
        pg <= p;
        wd <= 24'h00003C;
        sel_cnt = 0;
        comp_cnt = 0;
        seen = 4'h0;
        @(posedge sys_clk_in);
        req <= 1'b0;
        while (i < 40 && done !== 1'b1) begin
            @(negedge sys_clk_in);
            i++;
        end
        chk(sel_cnt, n);
        chk(seen, sel);
        chk(comp_cnt, nc);
        if (n > 0) chk(cap_a, xa);
    endtask

    initial begin
        repeat (12) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        apb(1'b0, MSD_OFF_CMSEN, 32'h0); chk(rd, 32'h0000000B);
        apb(1'b0, 8'h40, 32'h0); chk({31'h0, err}, 32'h1);
        apb(1'b1, MSD_OFF_DATA_WAIT, 32'h2);
        apb(1'b1, MSD_OFF_DMOVL, 32'h2);
        apb(1'b1, MSD_OFF_IO_WAIT, 32'h140);
        apb(1'b1, MSD_OFF_BYTE_WAIT, 32'h1);
        apb(1'b1, MSD_OFF_PMOVL, 32'h1);
        acc(MSD_SP_DM, 1'b0, 14'h0123, 8'h00, 3, 4'h2, 3, 14'h2123);
        chk({8'h00, rdata}, {18'h00015, 14'h2123});
        acc(MSD_SP_PM, 1'b0, 14'h2005, 8'h00, 3, 4'h1, 3, 14'h0005);
        acc(MSD_SP_IO, 1'b0, 14'h3C56, 8'h00, 6, 4'h8, 6, 14'h0456);
        acc(MSD_SP_BM, 1'b1, 14'h1234, 8'hA5, 2, 4'h4, 0, 14'h1234);
        chk({8'h00, cap_d}, 32'h00A53C00);
        apb(1'b1, MSD_OFF_DMOVL, 32'h0);
        apb(1'b1, MSD_OFF_PMOVL, 32'h0);
        acc(MSD_SP_DM, 1'b0, 14'h0123, 8'h00, 0, 4'h0, 0, 14'h0000);
        acc(MSD_SP_DM, 1'b0, 14'h3FE5, 8'h00, 0, 4'h0, 0, 14'h0000);
        chk({31'h0, creg}, 32'h1);
        acc(MSD_SP_PM, 1'b1, 14'h2005, 8'h00, 0, 4'h0, 0, 14'h0000);
        acc(MSD_SP_PM, 1'b0, 14'h2005, 8'h00, 0, 4'h0, 0, 14'h0000);
        chk({8'h00, rdata}, 32'h0000003C);
        chk({8'h00, fd}, 32'h0000003C);
        @(posedge sys_clk_in);
        map_pin <= 1'b1;
        acc(MSD_SP_PM, 1'b0, 14'h0100, 8'h00, 3, 4'h1, 3, 14'h0100);
        @(posedge sys_clk_in);
        grant <= 1'b1;
        acc(MSD_SP_PM, 1'b0, 14'h0100, 8'h00, 0, 4'h0, 0, 14'h0000);
        print_verdict();
    end
endmodule

// file: verilog/msd_decoder.sv
`timescale 1ns/1ps
// Overview of operation
// - Program RAM serves fetch and data together
// - Map low: upper program half overlay-routed
// - Program overlay: bit13 picks segment, 13 lsbs
// - Overlay registers change only by software
// - Map high: no overlays, low half external
// - Top 32 data words are control registers
// - Data overlay nonzero sends low half external
// - Data overlay: bit13 picks segment, 13 lsbs
// - Internal one cycle; external program/data use data waits
// - I/O uses eleven address lines only
// - Four 3-bit I/O wait settings
// - I/O region from address bits 10:9
// - Composite select timed like individual selects
// - Enabled select asserts composite select too
// - Composite select obeys bus grant release
// - Reset sets all enables except byte
// - Byte memory: 256 pages of 16K
// - Byte data on data lines 15:8
// - Page on data 23:16, offset on address
// - Byte accesses use byte wait setting
// - Separate I/O read and write requests
module msd_decoder
    import msd_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Core access port.
    input wire logic map_select_pin_in,
    input wire logic core_req_in,
    input wire logic [1:0] core_space_in,
    input wire logic core_write_in,
    input wire logic [13:0] core_addr_in,
    input wire logic [7:0] core_page_in,
    input wire logic [23:0] core_wdata_in,
    input wire logic [13:0] fetch_addr_in,
    output logic [23:0] fetch_data_out,
    output logic [23:0] core_rdata_out,
    output logic core_done_out,
    output logic core_busy_out,
    output logic core_ext_out,
    output logic core_creg_out,
    // External bus.
    input wire logic bus_grant_in,
    input wire logic [23:0] ext_data_in,
    output logic [23:0] ext_data_out,
    output logic ext_data_hi_oe_n_out,
    output logic ext_data_lo_oe_n_out,
    output logic [13:0] ext_addr_out,
    output logic ext_addr_oe_n_out,
    output logic ext_rd_n_out,
    output logic ext_wr_n_out,
    output logic program_memory_select_n_out,
    output logic data_memory_select_n_out,
    output logic byte_memory_select_n_out,
    output logic io_space_select_n_out,
    output logic composite_select_n_out
);

    // ************************************************************
    // Helpers.
    // ************************************************************

    // Overlay address: segment two raises bit 13, low 13 bits pass.
    function automatic logic [13:0] ovl_addr(input logic [MSD_OVL_W-1:0] ov, input logic [13:0] a);
        ovl_addr = {(ov == MSD_OVL_TWO), a[12:0]};
    endfunction

    // ************************************************************
    // Registers.
    // ************************************************************
    logic [MSD_OVL_W-1:0] program_overlay_selector_q;
    logic [MSD_OVL_W-1:0] data_overlay_selector_q;
    logic [MSD_WS_W-1:0] data_wait_setting_q;
    logic [MSD_WS_W-1:0] io_region_wait_settings_q [4];
    logic [3:0] composite_select_enables_q;
    logic [MSD_WS_W-1:0] byte_memory_wait_setting_q;
    logic pready_q, pslverr_q, apb_wr;
    logic [31:0] prdata_q, rd_d;

    msd_state_t st_q;
    logic [MSD_WS_W-1:0] cnt_q, ws_d;
    logic [3:0] sel_n_q, sel_d;
    logic comp_sel_n_q, ext_d, accept, pm_int_wr;
    logic [13:0] a_d, addr_q;
    logic [23:0] dout_q, rdata_q, fetch_q, ram_a, ram_b;
    logic done_q, busy_q, extf_q, creg_q;
    logic aoe_n_q, dhi_n_q, dlo_n_q, rd_n_q, wr_n_q;

    assign accept = core_req_in && st_q == MSD_ST_IDLE && !bus_grant_in;
    assign apb_wr = psel_in && penable_in && pready_q && pwrite_in;

    // Read mux for the APB slave; status shows the live access state.
    always_comb begin
        rd_d = 32'h0000_0000;
        case (paddr_in)
            MSD_OFF_PMOVL: rd_d[MSD_OVL_W-1:0] = program_overlay_selector_q;
            MSD_OFF_DMOVL: rd_d[MSD_OVL_W-1:0] = data_overlay_selector_q;
            MSD_OFF_DATA_WAIT: rd_d[MSD_WS_W-1:0] = data_wait_setting_q;
            MSD_OFF_IO_WAIT: rd_d[11:0] = {io_region_wait_settings_q[3], io_region_wait_settings_q[2],
                io_region_wait_settings_q[1], io_region_wait_settings_q[0]};
            MSD_OFF_CMSEN: rd_d[3:0] = composite_select_enables_q;
            MSD_OFF_BYTE_WAIT: rd_d[MSD_WS_W-1:0] = byte_memory_wait_setting_q;
            MSD_OFF_STATUS: rd_d[2:0] = {busy_q, extf_q, map_select_pin_in};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // APB handshake: ready is raised for the access phase, one wait-free cycle.
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel_in && !penable_in && !pready_q;
            if (psel_in && !penable_in) begin
                prdata_q <= pwrite_in ? 32'h0000_0000 : rd_d;
                pslverr_q <= paddr_in > MSD_OFF_STATUS || paddr_in[1:0] != 2'h0;
            end
        end
    end

    // Setting registers; written only at the completing APB edge.
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            program_overlay_selector_q <= MSD_OVL_RST;
            data_overlay_selector_q <= MSD_OVL_RST;
            data_wait_setting_q <= MSD_WS_RST;
            for (int i = 0; i < 4; i++) begin
                io_region_wait_settings_q[i] <= MSD_WS_RST;
            end
            composite_select_enables_q <= MSD_CMSEN_RST;
            byte_memory_wait_setting_q <= MSD_WS_RST;
        end else if (apb_wr) begin
            case (paddr_in)
                MSD_OFF_PMOVL: program_overlay_selector_q <= pwdata_in[MSD_OVL_W-1:0];
                MSD_OFF_DMOVL: data_overlay_selector_q <= pwdata_in[MSD_OVL_W-1:0];
                MSD_OFF_DATA_WAIT: data_wait_setting_q <= pwdata_in[MSD_WS_W-1:0];
                MSD_OFF_IO_WAIT: begin
                    for (int i = 0; i < 4; i++) begin
                        io_region_wait_settings_q[i] <= pwdata_in[3*i +: 3];
                    end
                end
                MSD_OFF_CMSEN: composite_select_enables_q <= pwdata_in[3:0];
                MSD_OFF_BYTE_WAIT: byte_memory_wait_setting_q <= pwdata_in[MSD_WS_W-1:0];
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Address decoding.
    // ************************************************************

    // Route each request; only overlay values 1 and 2 are meaningful.
    always_comb begin
        ext_d = 1'b0;
        a_d = core_addr_in;
        ws_d = data_wait_setting_q;
        sel_d = 4'h0;
        case (core_space_in)
            MSD_SP_PM: begin
                if (!map_select_pin_in) begin
                    if (core_addr_in >= MSD_HALF && program_overlay_selector_q != MSD_OVL_RST) begin
                        ext_d = 1'b1;
                        a_d = ovl_addr(program_overlay_selector_q, core_addr_in);
                    end
                end else if (core_addr_in < MSD_HALF) begin
                    ext_d = 1'b1;
                end
                sel_d[MSD_SEL_PM] = ext_d;
            end
            MSD_SP_DM: begin
                if (core_addr_in < MSD_HALF && data_overlay_selector_q != MSD_OVL_RST) begin
                    ext_d = 1'b1;
                    a_d = ovl_addr(data_overlay_selector_q, core_addr_in);
                end
                sel_d[MSD_SEL_DM] = ext_d;
            end
            MSD_SP_IO: begin
                ext_d = 1'b1;
                a_d = {3'h0, core_addr_in[10:0]};
                ws_d = io_region_wait_settings_q[core_addr_in[MSD_IO_LSB +: 2]];
                sel_d[MSD_SEL_IO] = 1'b1;
            end
            default: begin
                ext_d = 1'b1;
                ws_d = byte_memory_wait_setting_q;
                sel_d[MSD_SEL_BM] = 1'b1;
            end
        endcase
    end

    // ************************************************************
    // Program RAM.
    // ************************************************************
    assign pm_int_wr = accept && core_space_in == MSD_SP_PM && core_write_in && !ext_d;

    msd_pm_ram msd_pm_ram_inst (
        .sys_clk_in(sys_clk_in),
        .we_in(pm_int_wr),
        .waddr_in(core_addr_in),
        .wdata_in(core_wdata_in),
        .raddr_a_in(fetch_addr_in),
        .rdata_a_out(ram_a),
        .raddr_b_in(core_addr_in),
        .rdata_b_out(ram_b)
    );

    // Fetch port is read every cycle, independent of the data access.
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            fetch_q <= 24'h00_0000;
        end else begin
            fetch_q <= ram_a;
        end
    end

    // ************************************************************
    // Access sequencer.
    // ************************************************************

    // Requests in the external state are ignored, not queued, so the core
    // must watch busy before asking again.
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            st_q <= MSD_ST_IDLE;
            cnt_q <= MSD_WS_RST;
            sel_n_q <= MSD_SEL_NONE_N;
            comp_sel_n_q <= 1'b1;
            addr_q <= 14'h0000;
            dout_q <= 24'h00_0000;
            rdata_q <= 24'h00_0000;
            aoe_n_q <= 1'b1;
            dhi_n_q <= 1'b1;
            dlo_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            done_q <= 1'b0;
            busy_q <= 1'b0;
            extf_q <= 1'b0;
            creg_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (st_q)
                MSD_ST_IDLE: begin
                    if (accept) begin
                        extf_q <= ext_d;
                        creg_q <= core_space_in == MSD_SP_DM && core_addr_in >= MSD_CREG_BASE;
                        if (ext_d) begin
                            st_q <= MSD_ST_EXT;
                            busy_q <= 1'b1;
                            cnt_q <= ws_d;
                            sel_n_q <= ~sel_d;
                            comp_sel_n_q <= ~|(sel_d & composite_select_enables_q);
                            addr_q <= a_d;
                            aoe_n_q <= 1'b0;
                            rd_n_q <= core_write_in;
                            wr_n_q <= !core_write_in;
                            dhi_n_q <= !(core_write_in || core_space_in == MSD_SP_BM);
                            dlo_n_q <= !core_write_in;
                            dout_q <= core_space_in == MSD_SP_BM ? {core_page_in, core_wdata_in[7:0], 8'h00}
                                : core_wdata_in;
                        end else begin
                            done_q <= 1'b1;
                            rdata_q <= core_space_in == MSD_SP_PM ? ram_b : 24'h00_0000;
                        end
                    end
                end
                MSD_ST_EXT: begin
                    if (cnt_q == MSD_WS_RST) begin
                        st_q <= MSD_ST_IDLE;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        sel_n_q <= MSD_SEL_NONE_N;
                        comp_sel_n_q <= 1'b1;
                        aoe_n_q <= 1'b1;
                        dhi_n_q <= 1'b1;
                        dlo_n_q <= 1'b1;
                        rd_n_q <= 1'b1;
                        wr_n_q <= 1'b1;
                        rdata_q <= !sel_n_q[MSD_SEL_BM] ? {16'h0000, ext_data_in[15:8]} : ext_data_in;
                    end else begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
                default: st_q <= MSD_ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************
    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign fetch_data_out = fetch_q;
    assign core_rdata_out = rdata_q;
    assign core_done_out = done_q;
    assign core_busy_out = busy_q;
    assign core_ext_out = extf_q;
    assign core_creg_out = creg_q;
    assign ext_data_out = dout_q;
    assign ext_data_hi_oe_n_out = dhi_n_q;
    assign ext_data_lo_oe_n_out = dlo_n_q;
    assign ext_addr_out = addr_q;
    assign ext_addr_oe_n_out = aoe_n_q;
    assign ext_rd_n_out = rd_n_q;
    assign ext_wr_n_out = wr_n_q;
    assign program_memory_select_n_out = sel_n_q[MSD_SEL_PM];
    assign data_memory_select_n_out = sel_n_q[MSD_SEL_DM];
    assign byte_memory_select_n_out = sel_n_q[MSD_SEL_BM];
    assign io_space_select_n_out = sel_n_q[MSD_SEL_IO];
    assign composite_select_n_out = comp_sel_n_q;

    // ************************************************************
    // Assertions.
    // ************************************************************

    // Helper: cycles with a select low, and the wait count of that access.
    logic [3:0] hcnt_q;
    logic [MSD_WS_W-1:0] hws_q;
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            hcnt_q <= 4'h0;
            hws_q <= MSD_WS_RST;
        end else begin
            if (accept && ext_d) begin
                hws_q <= ws_d;
            end
            hcnt_q <= sel_n_q != MSD_SEL_NONE_N ? hcnt_q + 4'h1 : 4'h0;
        end
    end

    default clocking msd_cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    AST_PM_OVL: assert property (accept && core_space_in == MSD_SP_PM && !map_select_pin_in
        && core_addr_in >= MSD_HALF && program_overlay_selector_q != MSD_OVL_RST |=> !program_memory_select_n_out)
        else $error("program overlay access not external");
    AST_PM_A13: assert property (accept && ext_d && core_space_in == MSD_SP_PM && !map_select_pin_in
        |=> ext_addr_out == {$past(program_overlay_selector_q) == MSD_OVL_TWO, $past(core_addr_in[12:0])})
        else $error("program overlay address wrong");
    AST_MAP_HIGH: assert property (accept && core_space_in == MSD_SP_PM && map_select_pin_in
        |=> program_memory_select_n_out == ($past(core_addr_in) >= MSD_HALF))
        else $error("map high routing wrong");
    AST_DM_OVL: assert property (accept && core_space_in == MSD_SP_DM && core_addr_in < MSD_HALF
        && data_overlay_selector_q != MSD_OVL_RST
        |=> !data_memory_select_n_out ##0 ext_addr_out[13] == ($past(data_overlay_selector_q) == MSD_OVL_TWO))
        else $error("data overlay access wrong");
    AST_INT_ONE: assert property (accept && !ext_d |=> core_done_out && sel_n_q == MSD_SEL_NONE_N)
        else $error("internal access not one cycle");
    AST_IO_ADDR: assert property (accept && core_space_in == MSD_SP_IO
        |=> !io_space_select_n_out && ext_addr_out[10:0] == $past(core_addr_in[10:0]))
        else $error("io address wrong");
    AST_WAITS: assert property ($rose(core_done_out) && core_ext_out |-> hcnt_q == {1'b0, hws_q} + 4'h1)
        else $error("select length not waits plus one");
    AST_CMS: assert property (!composite_select_n_out == |(~sel_n_q & $past(composite_select_enables_q))
        || $past(st_q) == MSD_ST_EXT && st_q == MSD_ST_EXT)
        else $error("composite select out of step");
    AST_GRANT: assert property (bus_grant_in && st_q == MSD_ST_IDLE |=> composite_select_n_out
        && sel_n_q == MSD_SEL_NONE_N)
        else $error("select driven under grant");
    AST_RST_EN: assert property ($fell(reset_in) |-> composite_select_enables_q == MSD_CMSEN_RST)
        else $error("enable reset value wrong");
    AST_BM_LANES: assert property (accept && core_space_in == MSD_SP_BM && core_write_in
        |=> ext_data_out[23:16] == $past(core_page_in) && ext_data_out[15:8] == $past(core_wdata_in[7:0]))
        else $error("byte lanes wrong");

    COV_PM_OVL: cover property (!program_memory_select_n_out && ext_addr_out[13]);
    COV_IO_WAIT: cover property (!io_space_select_n_out && hcnt_q == 4'h4);
    COV_BM: cover property (!byte_memory_select_n_out && !composite_select_n_out);
    COV_MAP_HIGH: cover property (map_select_pin_in && !program_memory_select_n_out);

endmodule

// file: verilog/msd_pkg.sv
package msd_pkg;

    // ************************************************************
    // Register map on the APB slave (byte addresses).
    // ************************************************************
    localparam logic [7:0] MSD_OFF_PMOVL = 8'h00;
    localparam logic [7:0] MSD_OFF_DMOVL = 8'h04;
    localparam logic [7:0] MSD_OFF_DATA_WAIT = 8'h08;
    localparam logic [7:0] MSD_OFF_IO_WAIT = 8'h0C;
    localparam logic [7:0] MSD_OFF_CMSEN = 8'h10;
    localparam logic [7:0] MSD_OFF_BYTE_WAIT = 8'h14;
    localparam logic [7:0] MSD_OFF_STATUS = 8'h18;

    // ************************************************************
    // Field widths and values after reset.
    // ************************************************************
    localparam int MSD_WS_W = 3;
    localparam int MSD_OVL_W = 4;
    localparam logic [MSD_OVL_W-1:0] MSD_OVL_RST = 4'h0;
    localparam logic [MSD_WS_W-1:0] MSD_WS_RST = 3'h0;
    // Enable bits: 0 program, 1 data, 2 byte, 3 I/O; byte stays clear.
    localparam logic [3:0] MSD_CMSEN_RST = 4'hB;
    localparam logic [3:0] MSD_SEL_NONE_N = 4'hF;

    // ************************************************************
    // Select bit positions and request spaces.
    // ************************************************************
    localparam int MSD_SEL_PM = 0;
    localparam int MSD_SEL_DM = 1;
    localparam int MSD_SEL_BM = 2;
    localparam int MSD_SEL_IO = 3;
    localparam logic [1:0] MSD_SP_PM = 2'h0;
    localparam logic [1:0] MSD_SP_DM = 2'h1;
    localparam logic [1:0] MSD_SP_IO = 2'h2;
    localparam logic [1:0] MSD_SP_BM = 2'h3;

    // ************************************************************
    // Address map figures.
    // ************************************************************
    localparam logic [13:0] MSD_HALF = 14'h2000;
    localparam logic [13:0] MSD_CREG_BASE = 14'h3FE0;
    localparam logic [MSD_OVL_W-1:0] MSD_OVL_TWO = 4'h2;
    localparam int MSD_IO_LSB = 9;
    localparam int MSD_PM_WORDS = 16384;
    localparam int MSD_PM_W = 24;

    typedef enum logic {MSD_ST_IDLE, MSD_ST_EXT} msd_state_t;

endpackage

// file: verilog/msd_pm_ram.sv
`timescale 1ns/1ps
module msd_pm_ram
    import msd_pkg::*;
(
    // Clock.
    input wire logic sys_clk_in,
    // Write port.
    input wire logic we_in,
    input wire logic [13:0] waddr_in,
    input wire logic [MSD_PM_W-1:0] wdata_in,
    // Two read ports, fetch and data.
    input wire logic [13:0] raddr_a_in,
    output logic [MSD_PM_W-1:0] rdata_a_out,
    input wire logic [13:0] raddr_b_in,
    output logic [MSD_PM_W-1:0] rdata_b_out
);

    logic [MSD_PM_W-1:0] mem_q [MSD_PM_WORDS];

    // Both reads are direct so a fetch and a data access share one cycle.
    assign rdata_a_out = mem_q[raddr_a_in];
    assign rdata_b_out = mem_q[raddr_b_in];

    // Single write port; contents have no reset.
    always_ff @(posedge sys_clk_in) begin
        if (we_in) begin
            mem_q[waddr_in] <= wdata_in;
        end
    end

endmodule
